// [rtl/ddrstb_pkg.sv]
// ddrstb_pkg: shared constants and types for the data strobe block.
// assumes a 50 MHz core clock; the link strobe is sampled, not used as clock.
package ddrstb_pkg;

  // core clock and beat timing, both times in nanoseconds
  localparam int CORE_PERIOD_NS = 20;
  localparam int BEAT_HALF_NS = 80; // one read beat lasts one strobe half period
  // least time, so round up to whole cycles
  localparam int BEAT_CYC = (BEAT_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int BEAT_CNT_W = 4;

  // extended_mode_reg field positions within the mode load word
  localparam int EMR_WORD_W = 16;
  localparam int EMR_COMP_OFF_BIT = 10; // 1 releases the complementary pins
  localparam int EMR_RDS_EN_BIT = 11; // 1 enables the redundant read strobe

  // values after reset: complementary strobes in use, redundant strobe off
  localparam logic RST_DIFF_MODE = 1'h1;
  localparam logic RST_RDS_MODE = 1'h0;

  // read side sequencer
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_PRE,
    RD_BURST,
    RD_POST
  } ddrstb_rd_state_e;

  // a strobe edge of either polarity between two samples
  function automatic logic ddrstb_edge(input logic prev, input logic cur);
    ddrstb_edge = prev ^ cur;
  endfunction : ddrstb_edge

endpackage : ddrstb_pkg

// [rtl/ddrstb_sync.sv]
// ddrstb_sync: two-flop synchroniser for a group of pin levels.
// assumes each bit is a level; bits are not kept coherent with each other.
`timescale 1ns/1ps
module ddrstb_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // the first stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // both stages clear on reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : ddrstb_sync

// [rtl/ddrstb_fifo.sv]
// ddrstb_fifo: small synchronous fifo with a registered output word.
// assumes one clock; capacity is DEPTH words plus the output register.
`timescale 1ns/1ps
module ddrstb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d;
  logic [AW-1:0] rd_ptr_q, rd_ptr_d;
  logic [AW:0] count_q, count_d;
  logic out_valid_q, out_valid_d;
  logic [W-1:0] out_data_q, out_data_d;
  logic push, pop;

  // pointer and count update; the output register prefetches one word
  always_comb begin
    push = in_valid_in && in_ready_out;
    pop = (count_q != '0) && (!out_valid_q || out_ready_in);
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    out_valid_d = out_valid_q;
    out_data_d = out_data_q;
    if (pop) begin
      out_valid_d = 1'b1;
      out_data_d = mem_q[rd_ptr_q];
    end else if (out_ready_in) begin
      out_valid_d = 1'b0;
    end
  end

  // control state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
    end
  end

  // storage needs no reset; empty slots are never read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // full is honest: the stored words reach DEPTH
  assign in_ready_out = (count_q != (AW+1)'(DEPTH));
  assign out_valid_out = out_valid_q;
  assign out_data_out = out_data_q;

endmodule : ddrstb_fifo

// [rtl/ddrstb_core.sv]
// ddrstb_core: data strobe, data pin and mask handling of the memory device.
// assumes strobe, data and mask pins are sampled by core_clk_in through
// two flops; mode load and read data come from logic on the same clock.
`timescale 1ns/1ps
module ddrstb_core #(
  parameter int ORG = 8, // data width of the organisation: 4, 8 or 16
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // mode register load from the command decoder
  input wire logic mode_load_in,
  input wire logic [ddrstb_pkg::EMR_WORD_W-1:0] mode_word_in,
  output logic diff_strobe_mode_out,
  output logic redundant_strobe_mode_out,
  // read data from the array, one word per strobe edge
  input wire logic rd_valid_in,
  input wire logic [ORG-1:0] rd_data_in,
  output logic rd_ready_out,
  output logic rd_active_out,
  // write beats towards the array, one valid bit per strobe lane
  output logic [(ORG == 16 ? 2 : 1)-1:0] wr_valid_out,
  output logic [ORG-1:0] wr_data_out,
  // data pins; on x8 these are the lower nibble only
  input wire logic [(ORG == 8 ? 4 : ORG)-1:0] dq_in,
  output logic [(ORG == 8 ? 4 : ORG)-1:0] dq_out,
  output logic [(ORG == 8 ? 4 : ORG)-1:0] dq_oe_out,
  // no_function_pins: upper data nibble on x8
  input wire logic [3:0] no_function_pins_in,
  output logic [3:0] no_function_pins_out,
  output logic [3:0] no_function_pins_oe_out,
  // strobes; bit 0 lower_byte_strobe, bit 1 upper_byte_strobe on x16
  input wire logic [(ORG == 16 ? 2 : 1)-1:0] data_strobe_in,
  output logic [(ORG == 16 ? 2 : 1)-1:0] data_strobe_out,
  output logic [(ORG == 16 ? 2 : 1)-1:0] data_strobe_oe_out,
  output logic [(ORG == 16 ? 2 : 1)-1:0] data_strobe_n_out,
  output logic [(ORG == 16 ? 2 : 1)-1:0] data_strobe_n_oe_out,
  // write_data_mask per lane; unused on x8, where the mask shares a pin
  input wire logic [(ORG == 16 ? 2 : 1)-1:0] write_data_mask_in,
  // redundant_read_strobe pair, x8 only
  input wire logic redundant_read_strobe_in,
  output logic redundant_read_strobe_out,
  output logic redundant_read_strobe_oe_out,
  output logic redundant_read_strobe_n_out,
  output logic redundant_read_strobe_n_oe_out
);

  localparam int NLANE = (ORG == 16) ? 2 : 1;
  localparam int LANE_W = ORG / NLANE;
  localparam int PIN_W = (ORG == 8) ? 4 : ORG;
  localparam bit IS_X8 = (ORG == 8);
  localparam int SYNC_W = PIN_W + 4 + 2 * NLANE + 1;
  localparam logic [ddrstb_pkg::BEAT_CNT_W-1:0] BEAT_LAST =
    ddrstb_pkg::BEAT_CNT_W'(ddrstb_pkg::BEAT_CYC - 1);

  // mode state
  logic diff_q, diff_d;
  logic rds_q, rds_d;
  // read sequencer state
  ddrstb_pkg::ddrstb_rd_state_e st_q, st_d;
  logic [ddrstb_pkg::BEAT_CNT_W-1:0] tmr_q, tmr_d;
  logic strobe_q, strobe_d;
  logic [ORG-1:0] rdat_q, rdat_d;
  // write capture state
  logic [NLANE-1:0] stb_prev_q, stb_prev_d;
  logic [NLANE-1:0] wval_q, wval_d;
  logic [ORG-1:0] wdat_q, wdat_d;
  // synchronised pins and derived values
  logic [SYNC_W-1:0] pins_async, pins_sync;
  logic [PIN_W-1:0] dq_s;
  logic [3:0] nf_s;
  logic [NLANE-1:0] stb_s;
  logic [NLANE-1:0] dm_s;
  logic redundant_read_strobe_n_s;
  logic [ORG-1:0] data_s;
  logic [NLANE-1:0] mask_s;
  logic fifo_valid, fifo_ready;
  logic [ORG-1:0] fifo_data;
  logic beat_tick, drive;

  // every pin input passes two flops before any logic reads it
  assign pins_async = {redundant_read_strobe_in, write_data_mask_in,
                       data_strobe_in, no_function_pins_in, dq_in};

  ddrstb_sync #(
    .W(SYNC_W)
  ) u_pin_sync (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign dq_s = pins_sync[PIN_W-1:0];
  assign nf_s = pins_sync[PIN_W+3:PIN_W];
  assign stb_s = pins_sync[PIN_W+4+NLANE-1:PIN_W+4];
  assign dm_s = pins_sync[PIN_W+4+2*NLANE-1:PIN_W+4+NLANE];
  assign redundant_read_strobe_n_s = pins_sync[SYNC_W-1];

  // read words wait here so the array side sees back-pressure per beat
  ddrstb_fifo #(
    .W(ORG),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_valid_in(rd_valid_in),
    .in_data_in(rd_data_in),
    .in_ready_out(rd_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_ready)
  );

  // assemble the full data word and the per-lane mask
  generate
    if (IS_X8) begin : g_x8
      assign data_s = {nf_s, dq_s};
      // with the redundant strobe on, its pin carries no mask
      assign mask_s = rds_q ? 1'b0 : redundant_read_strobe_n_s;
    end else begin : g_other
      assign data_s = dq_s;
      assign mask_s = dm_s;
    end
  endgenerate

  // mode fields take effect on each load; until then the reset values hold
  always_comb begin
    diff_d = diff_q;
    rds_d = rds_q;
    if (mode_load_in) begin
      diff_d = !mode_word_in[ddrstb_pkg::EMR_COMP_OFF_BIT];
      rds_d = IS_X8 && mode_word_in[ddrstb_pkg::EMR_RDS_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      diff_q <= ddrstb_pkg::RST_DIFF_MODE;
      rds_q <= ddrstb_pkg::RST_RDS_MODE;
    end else begin
      diff_q <= diff_d;
      rds_q <= rds_d;
    end
  end

  // read sequencer: preamble low beat, one edge per word, postamble low beat
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    strobe_d = strobe_q;
    rdat_d = rdat_q;
    beat_tick = (tmr_q == '0);
    fifo_ready = 1'b0;
    if (!beat_tick) begin
      tmr_d = tmr_q - 1'b1;
    end
    unique case (st_q)
      ddrstb_pkg::RD_IDLE: begin
        // no read starts in a cycle whose synchronised strobe shows a write edge
        if (fifo_valid && (stb_s == stb_prev_q)) begin
          st_d = ddrstb_pkg::RD_PRE;
          tmr_d = BEAT_LAST;
          strobe_d = 1'b0;
        end
      end
      ddrstb_pkg::RD_PRE, ddrstb_pkg::RD_BURST: begin
        if (beat_tick) begin
          tmr_d = BEAT_LAST;
          if (fifo_valid) begin
            fifo_ready = 1'b1;
            rdat_d = fifo_data;
            strobe_d = !strobe_q;
            st_d = ddrstb_pkg::RD_BURST;
          end else begin
            strobe_d = 1'b0;
            st_d = ddrstb_pkg::RD_POST;
          end
        end
      end
      ddrstb_pkg::RD_POST: begin
        if (beat_tick) begin
          st_d = ddrstb_pkg::RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= ddrstb_pkg::RD_IDLE;
      tmr_q <= '0;
      strobe_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      strobe_q <= strobe_d;
      rdat_q <= rdat_d;
    end
  end

  // pins are driven for the whole read window and released otherwise
  assign drive = (st_q != ddrstb_pkg::RD_IDLE);

  // write capture: each lane samples data and mask on both strobe edges
  always_comb begin
    stb_prev_d = stb_s;
    wval_d = '0;
    wdat_d = wdat_q;
    for (int l = 0; l < NLANE; l++) begin
      // while reading, the strobe pins echo our own drive and are ignored
      if (ddrstb_pkg::ddrstb_edge(stb_prev_q[l], stb_s[l]) && !drive) begin
        wval_d[l] = !mask_s[l];
        wdat_d[l*LANE_W +: LANE_W] = data_s[l*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stb_prev_q <= '0;
      wval_q <= '0;
      wdat_q <= '0;
    end else begin
      stb_prev_q <= stb_prev_d;
      wval_q <= wval_d;
      wdat_q <= wdat_d;
    end
  end

  // one strobe pair per lane, all lanes following the same read beat
  generate
    for (genvar g = 0; g < NLANE; g++) begin : g_lane
      assign data_strobe_out[g] = strobe_q;
      assign data_strobe_oe_out[g] = drive;
      assign data_strobe_n_out[g] = !strobe_q;
      // complementary pin left undriven when released by the mode bit
      assign data_strobe_n_oe_out[g] = drive && diff_q;
    end
  endgenerate

  // data pins, upper nibble on the no-function pins for x8
  generate
    if (IS_X8) begin : g_nf_x8
      assign dq_out = rdat_q[3:0];
      assign dq_oe_out = {PIN_W{drive}};
      assign no_function_pins_out = rdat_q[7:4];
      assign no_function_pins_oe_out = {4{drive}};
    end else begin : g_nf_none
      assign dq_out = rdat_q[PIN_W-1:0];
      assign dq_oe_out = {PIN_W{drive}};
      assign no_function_pins_out = 4'h0;
      assign no_function_pins_oe_out = 4'h0;
    end
  endgenerate

  // redundant pair: x8 only, reads only; with the mode off its input is the x8 write mask
  assign redundant_read_strobe_out = strobe_q;
  assign redundant_read_strobe_oe_out = drive && rds_q;
  assign redundant_read_strobe_n_out = !strobe_q;
  assign redundant_read_strobe_n_oe_out = drive && rds_q && diff_q;

  // status and user-side outputs
  assign diff_strobe_mode_out = diff_q;
  assign redundant_strobe_mode_out = rds_q;
  assign rd_active_out = drive;
  assign wr_valid_out = wval_q;
  assign wr_data_out = wdat_q;

endmodule : ddrstb_core

// [tb/ddrstb_core_chk.sv]
// ddrstb_core_chk: port assertions for the data strobe block.
// assumes it is bound to ddrstb_core and sees only that module's ports.
`timescale 1ns/1ps
module ddrstb_core_chk #(
  parameter int ORG = 8,
  parameter int NL = (ORG == 16 ? 2 : 1)
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // mode load
  input wire logic mode_load_in,
  input wire logic [ddrstb_pkg::EMR_WORD_W-1:0] mode_word_in,
  input wire logic diff_strobe_mode_out,
  input wire logic redundant_strobe_mode_out,
  // read window and pins
  input wire logic rd_active_out,
  input wire logic [NL-1:0] data_strobe_out,
  input wire logic [NL-1:0] data_strobe_oe_out,
  input wire logic [NL-1:0] data_strobe_n_oe_out,
  input wire logic [3:0] no_function_pins_oe_out,
  input wire logic redundant_read_strobe_oe_out,
  input wire logic redundant_read_strobe_n_oe_out,
  // write side
  input wire logic [NL-1:0] data_strobe_in,
  input wire logic redundant_read_strobe_in,
  input wire logic [NL-1:0] wr_valid_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // mode state follows loads only
  a_diff_off_load: assert property (mode_load_in &&
    mode_word_in[ddrstb_pkg::EMR_COMP_OFF_BIT] |=> !diff_strobe_mode_out)
    else $error("complementary pins still in use after release load");
  a_mode_hold: assert property (!mode_load_in |=>
    $stable(diff_strobe_mode_out)) else $error("diff mode moved unloaded");
  // pin enables against modes
  a_comp_oe_mode: assert property (data_strobe_n_oe_out ==
    (data_strobe_oe_out & {NL{diff_strobe_mode_out}}))
    else $error("complementary strobe enable wrong");
  a_rds_oe_read: assert property (redundant_read_strobe_oe_out ==
    (rd_active_out && redundant_strobe_mode_out))
    else $error("redundant strobe enable wrong");
  a_rds_n_oe: assert property (redundant_read_strobe_n_oe_out ==
    (redundant_read_strobe_oe_out && diff_strobe_mode_out))
    else $error("complementary redundant enable wrong");
  a_nf_pins_oe: assert property (no_function_pins_oe_out ==
    (ORG == 8 ? {4{rd_active_out}} : 4'h0))
    else $error("upper nibble enable wrong");
  // read window opens with a low preamble, then a rising first edge
  a_rd_preamble: assert property ($rose(rd_active_out) |->
    (data_strobe_out[0] == 1'b0) [*4] ##1 data_strobe_out[0])
    else $error("read preamble wrong");
  // write beats
  a_wr_quiet_read: assert property ((rd_active_out) [*5] |->
    wr_valid_out == '0) else $error("write beat during read");
  a_wr_beat_seen: assert property (ORG == 8 &&
    $changed(data_strobe_in[0]) && !rd_active_out &&
    (redundant_strobe_mode_out || !redundant_read_strobe_in) |->
    ##[2:4] wr_valid_out[0]) else $error("unmasked write beat lost");
  a_wr_mask_drop: assert property (wr_valid_out[0] |->
    ORG != 8 || $past(redundant_strobe_mode_out, 3) ||
    !$past(redundant_read_strobe_in, 3)) else $error("masked beat kept");

  c_read: cover property ($rose(rd_active_out));
  c_write: cover property (wr_valid_out[0]);
  c_rds_on: cover property (rd_active_out && redundant_read_strobe_n_oe_out);
  c_release: cover property (mode_load_in && mode_word_in[10]);
endmodule : ddrstb_core_chk

bind ddrstb_core ddrstb_core_chk #(.ORG(ORG)) u_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in),
  .mode_load_in(mode_load_in), .mode_word_in(mode_word_in),
  .diff_strobe_mode_out(diff_strobe_mode_out),
  .redundant_strobe_mode_out(redundant_strobe_mode_out),
  .rd_active_out(rd_active_out), .data_strobe_out(data_strobe_out),
  .data_strobe_oe_out(data_strobe_oe_out),
  .data_strobe_n_oe_out(data_strobe_n_oe_out),
  .no_function_pins_oe_out(no_function_pins_oe_out),
  .redundant_read_strobe_oe_out(redundant_read_strobe_oe_out),
  .redundant_read_strobe_n_oe_out(redundant_read_strobe_n_oe_out),
  .data_strobe_in(data_strobe_in),
  .redundant_read_strobe_in(redundant_read_strobe_in),
  .wr_valid_out(wr_valid_out));

// [tb/ddrstb_ctrl_model.sv]
// ddrstb_ctrl_model: controller side of the x8 write pins.
// assumes calls start 1 ns after a core edge; strobe idles between frames.
`timescale 1ns/1ps
module ddrstb_ctrl_model (
  // pins towards the device
  output logic strobe_out,
  output logic [7:0] data_out,
  output logic mask_out
);
  initial begin
    strobe_out = 1'h0;
    data_out = 8'h00;
    mask_out = 1'h0;
  end
  // one beat of a 160 ns strobe: edge centred in the data bit
  task automatic write_beat(input logic [7:0] d, input logic m);
    data_out = d;
    mask_out = m;
    #40 strobe_out = ~strobe_out;
    #40;
  endtask : write_beat
  // hold time over: show changed values, never the last ones
  task automatic release_pins;
    data_out = ~data_out;
    mask_out = ~mask_out;
  endtask : release_pins
endmodule : ddrstb_ctrl_model

// [tb/tb_ddrstb_core.sv]
// tb_ddrstb_core: self-checking bench for the x8 data strobe block.
// assumes the controller model on the write pins and a 50 MHz core clock.
`timescale 1ns/1ps
module tb_ddrstb_core;
  logic clk, rst, ld, rdv, st_o, st_oe, st_n_o, st_n_oe, diff, rds, rdy;
  logic act, wv, rs_o, rs_oe, rs_n_oe, m_st, m_mask, prev_st;
  logic [15:0] mw;
  logic [7:0] rdd, m_d, wr_d;
  logic [3:0] dq_o, dq_oe, nf_o, nf_oe;
  logic [7:0] rdq[$], wrq[$];
  int n_errors, n_checks;
  // pin levels from whichever side drives
  wire st_pin = st_oe ? st_o : m_st;
  wire rs_pin = rs_oe ? rs_o : m_mask;
  wire [3:0] dq_pin = dq_oe[0] ? dq_o : m_d[3:0];
  wire [3:0] nf_pin = nf_oe[0] ? nf_o : m_d[7:4];

  ddrstb_ctrl_model u_ctrl (.strobe_out(m_st), .data_out(m_d),
    .mask_out(m_mask));
  ddrstb_core #(.ORG(8), .FIFO_DEPTH(8)) DUT (.core_clk_in(clk),
    .rst_in(rst), .mode_load_in(ld), .mode_word_in(mw),
    .diff_strobe_mode_out(diff), .redundant_strobe_mode_out(rds),
    .rd_valid_in(rdv), .rd_data_in(rdd), .rd_ready_out(rdy),
    .rd_active_out(act), .wr_valid_out(wv), .wr_data_out(wr_d),
    .dq_in(dq_pin), .dq_out(dq_o), .dq_oe_out(dq_oe),
    .no_function_pins_in(nf_pin), .no_function_pins_out(nf_o),
    .no_function_pins_oe_out(nf_oe), .data_strobe_in(st_pin),
    .data_strobe_out(st_o), .data_strobe_oe_out(st_oe),
    .data_strobe_n_out(st_n_o), .data_strobe_n_oe_out(st_n_oe),
    .write_data_mask_in(1'h1), .redundant_read_strobe_in(rs_pin),
    .redundant_read_strobe_out(rs_o), .redundant_read_strobe_oe_out(rs_oe),
    .redundant_read_strobe_n_out(), .redundant_read_strobe_n_oe_out(rs_n_oe));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // collect read words at each driven strobe edge, and write beats
  always @(posedge clk) begin
    if (st_oe && st_o !== prev_st) rdq.push_back({nf_o, dq_o});
    prev_st <= st_o;
    if (wv) wrq.push_back(wr_d);
  end

  task automatic chk(input string what, input logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task automatic t_reset;
    chk("diff", 1'h1, diff);
    chk("rds", 1'h0, rds);
    chk("strobe oe", 1'h0, st_oe);
    chk("strobe_n", 1'h1, st_n_o);
    chk("ready", 1'h1, rdy);
    $display("reset test done");
  endtask : t_reset

  // load comp-release bit and redundant enable
  task automatic t_mode(input logic b10, input logic b11);
    mw = 16'h0000;
    mw[10] = b10;
    mw[11] = b11;
    ld = 1'h1;
    @(posedge clk);
    #1 ld = 1'h0;
    mw = 16'hffff;
    chk("diff", !b10, diff);
    chk("rds", b11, rds);
    $display("mode test done");
  endtask : t_mode

  // four beats, odd ones masked on the shared pin
  task automatic t_write(input logic r);
    logic [7:0] d[4];
    logic [7:0] e[$];
    d = '{8'ha5, 8'h5a, 8'hc3, 8'h3c};
    wrq.delete();
    for (int i = 0; i < 4; i++) begin
      u_ctrl.write_beat(d[i], i[0]);
      if (r || !i[0]) e.push_back(d[i]);
    end
    u_ctrl.release_pins();
    repeat (4) @(posedge clk);
    #1;
    chk("wr count", 8'(e.size()), 8'(wrq.size()));
    foreach (e[i]) chk("wr data", e[i], wrq[i]);
    $display("write test done");
  endtask : t_write

  // push words (20 tries counting refusals when fill, else 2), then watch the window
  task automatic t_read(input logic r, input logic dm, input logic fill);
    int n;
    int refused;
    logic ok;
    logic seen;
    n = 0;
    refused = 0;
    seen = 1'h0;
    rdq.delete();
    rdv = 1'h1;
    repeat (fill ? 20 : 2) begin
      rdd = 8'h30 + 8'(n);
      ok = rdy;
      @(posedge clk);
      #1;
      if (ok) n++;
      else refused++;
    end
    rdv = 1'h0;
    if (fill) chk("refused", 1'h1, refused > 0);
    for (int c = 0; c < 300 && !(seen && !act); c++) begin
      if (act && !seen) begin
        seen = 1'h1;
        chk("rds oe", r, rs_oe);
        chk("rds_n oe", r && dm, rs_n_oe);
        chk("strobe_n oe", dm, st_n_oe);
        chk("nf oe", 4'hf, nf_oe);
      end
      @(posedge clk);
      #1;
    end
    if (act || !seen) begin
      n_errors++;
      $display("wrong value read window expected closed seen open");
    end else begin
      for (int i = 0; i < n; i++)
        chk("rd word", 8'h30 + 8'(i), rdq[i]);
    end
    $display("read test done");
  endtask : t_read

  initial begin
    rst = 1'h1;
    ld = 1'h0;
    rdv = 1'h0;
    mw = 16'h0000;
    rdd = 8'h00;
    n_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    #1 rst = 1'h0;
    t_reset();
    t_read(1'h0, 1'h1, 1'h1);
    for (int m = 0; m < 4; m++) begin
      t_mode(m[0], m[1]);
      t_write(m[1]);
      t_read(m[1], !m[0], 1'h0);
    end
    results();
  end
endmodule : tb_ddrstb_core
